// ---- hw/bit_rate_divider.sv ----
// Half bit period enable from the even prescale and the clock rate value.
// Assumes the settings are held steady while a frame is in progress.
`timescale 1ns/10ps
`default_nettype none
module bit_rate_divider import ssp_pkg::*; (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [7:0] clock_prescale_divisor_i,
    input wire logic [7:0] serial_clock_rate_i,
    output logic half_tick_o
);
    div_state_t s;
    div_state_t n;
    logic [6:0] half_pre;

    always_comb begin
        n = s;
        n.tick = 1'b0;
        half_pre = clock_prescale_divisor_i[7:1];
        if (half_pre == 7'h00) begin
            half_pre = 7'h01;
        end
        if (s.pre >= half_pre - 7'h01) begin
            n.pre = 7'h00;
            if (s.cnt >= serial_clock_rate_i) begin
                n.cnt = 8'h00;
                n.tick = 1'b1;
            end else begin
                n.cnt = s.cnt + 8'h01;
            end
        end else begin
            n.pre = s.pre + 7'h01;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            s <= DIV_RESET;
        end else begin
            s <= n;
        end
    end

    assign half_tick_o = s.tick;
endmodule : bit_rate_divider
`default_nettype wire

// ---- hw/serial_port.sv ----
// Synchronous serial port core: framing engine, pin drive and status.
// Assumes configuration and CPU strobes come from logic on clk_i.
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - System clock is first divided by an even prescale from 2 to 254.
// - Then divided by one plus the rate value, 1 to 256.
// - System clock must be 2x serial clock as master, 12x as slave.
// - Each CPU data write pushes one word into an 8x16 transmit store.
// - Received words enter an 8x16 receive store; each CPU read pops one.
// - Four conditions: transmit service, receive service, timeout, overrun.
// - All enabled conditions are ORed onto one interrupt line.
// - Each condition has a mask bit; one enables it.
// - Raw and masked state of every condition are both readable.
// - Words of 4 to 16 bits are shifted most significant bit first.
// - Serial clock idles inactive and toggles during a word, plus one period after it in pulsed format.
// - Idle serial clock with data still received raises the timeout.
// - In SPI and half-duplex formats frame select is low all frame.
// - Pulsed format: frame sync high one period from a rising edge.
// - Pulsed format: outputs change on rising, inputs sampled on falling.
// - Pulsed format idle: clock and sync low, transmit data released.
// - Pulsed format: sync pulse, load head word, MSB on next rise.
// - Pulsed format: received word stored on first rise after LSB as master, on the LSB falling edge as slave.
// - Half-duplex: 8-bit message out, nothing received, then reply.
// - SPI polarity clear idles clock low; set idles clock high.
// - SPI phase clear samples on first edge; set on second edge.
// - SPI phase clear: frame select raised between consecutive words.
// - SPI phase set: frame select held low between consecutive words.
// - Internal loopback test mode besides master or slave operation.
module serial_port import ssp_pkg::*; (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire cfg_t cfg_i,
    input wire logic tx_wr_i,
    input wire logic [DATA_W-1:0] tx_data_i,
    input wire logic rx_rd_i,
    input wire logic clear_timeout_i,
    input wire logic clear_overrun_i,
    input wire logic serial_clock_pin_i,
    input wire logic frame_select_pin_i,
    input wire logic receive_data_pin_i,
    output pins_t pins_o,
    output logic [DATA_W-1:0] rx_data_o,
    output logic [LVL_W-1:0] tx_level_o,
    output logic [LVL_W-1:0] rx_level_o,
    output logic [3:0] raw_status_o,
    output logic [3:0] masked_status_o,
    output logic irq_o
);
    core_t s;
    core_t n;
    logic half_tick;
    logic tick;
    logic tx_pop;
    logic rx_push;
    logic [DATA_W-1:0] rx_word;
    logic [DATA_W-1:0] tx_head;
    logic [LVL_W-1:0] tx_level;
    logic [LVL_W-1:0] rx_level;
    logic pulsed;
    logic halfdup;
    logic late;
    logic rxd;
    logic slave_start;
    logic [4:0] width;
    logic [4:0] total;
    logic [4:0] first_rx;
    logic [4:0] first_tx;

    function automatic pins_t idle_pins(input cfg_t c);
        pins_t p;
        p.serial_clock_pin = (c.format == FMT_SPI) && c.clock_polarity_bit;
        p.serial_clock_pin_oe_n = !c.master;
        p.frame_select_pin = (c.format != FMT_PULSED);
        p.frame_select_pin_oe_n = !c.master;
        p.transmit_data_pin = 1'b0;
        p.transmit_data_pin_oe_n = 1'b1;
        return p;
    endfunction : idle_pins

    function automatic logic [DATA_W-1:0] load_word(
        input logic [DATA_W-1:0] d, input cfg_t c);
        if (c.format == FMT_HALF) begin
            return {d[7:0], 8'h00};
        end
        return d << (4'hf - c.size_m1);
    endfunction : load_word

    bit_rate_divider divider (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .clock_prescale_divisor_i(cfg_i.clock_prescale_divisor),
        .serial_clock_rate_i(cfg_i.serial_clock_rate),
        .half_tick_o(half_tick)
    );

    word_fifo tx_fifo (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .wr_i(tx_wr_i),
        .wr_data_i(tx_data_i),
        .rd_i(tx_pop),
        .head_o(tx_head),
        .count_o(tx_level)
    );

    word_fifo rx_fifo (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .wr_i(rx_push),
        .wr_data_i(rx_word),
        .rd_i(rx_rd_i),
        .head_o(rx_data_o),
        .count_o(rx_level)
    );

    always_comb begin
        n = s;
        tx_pop = 1'b0;
        rx_push = 1'b0;
        n.sync1 = {serial_clock_pin_i, frame_select_pin_i, receive_data_pin_i};
        n.sync2 = s.sync1;
        n.sclk_prev = s.sync2[2];
        n.fss_prev = s.sync2[1];
        if (half_tick) begin
            n.period = !s.period;
        end
        pulsed = (cfg_i.format == FMT_PULSED);
        halfdup = (cfg_i.format == FMT_HALF);
        // pulsed and SPI phase set sample on the second edge.
        late = pulsed || (!halfdup && cfg_i.clock_phase_bit);
        rxd = cfg_i.loopback ? s.pins.transmit_data_pin : s.sync2[0];
        // slave edges come from the synchronised pin.
        tick = cfg_i.master ? half_tick : (s.sync2[2] != s.sclk_prev);
        width = {1'b0, cfg_i.size_m1} + 5'h01;
        total = width;
        first_rx = 5'h00;
        first_tx = 5'h00;
        if (halfdup) begin
            total = CTRL_MSG_BITS + TURN_BITS + width;
            first_rx = CTRL_MSG_BITS + TURN_BITS;
        end else if (pulsed) begin
            total = width + PULSED_RX_FIRST;
            first_rx = PULSED_RX_FIRST;
            first_tx = PULSED_RX_FIRST;
        end
        if (pulsed) begin
            slave_start = tick && s.sync2[2] && s.sync2[1];
        end else begin
            slave_start = !s.sync2[1] && (s.fss_prev || cfg_i.clock_phase_bit);
        end
        case (s.st)
            ST_IDLE: begin
                n.pins = idle_pins(cfg_i);
                n.bit_idx = 5'h00;
                n.half = 1'b0;
                n.trail = 1'b0;
                // start once the head holds data.
                if (cfg_i.enable && cfg_i.master && tx_level != '0) begin
                    n.tx_sh = load_word(tx_head, cfg_i);
                    tx_pop = 1'b1;
                    n.pins.transmit_data_pin_oe_n = 1'b0;
                    if (pulsed) begin
                        n.st = ST_BITS;
                    end else begin
                        n.pins.frame_select_pin = 1'b0;
                        n.st = ST_LEAD;
                    end
                end else if (cfg_i.enable && !cfg_i.master && slave_start) begin
                    n.tx_sh = (tx_level != '0) ? load_word(tx_head, cfg_i) : '0;
                    tx_pop = (tx_level != '0);
                    n.pins.transmit_data_pin_oe_n = 1'b0;
                    n.half = pulsed;
                    n.st = ST_BITS;
                end
            end
            ST_LEAD: begin
                if (tick) begin
                    n.st = ST_BITS;
                end
            end
            ST_BITS: begin
                if (!cfg_i.master && !pulsed && s.sync2[1]) begin
                    n.st = ST_IDLE;
                end else if (tick) begin
                    // clock toggles within a word, and for one period past it in pulsed format.
                    if (cfg_i.master) begin
                        n.pins.serial_clock_pin = !s.pins.serial_clock_pin;
                    end
                    if (!s.half) begin
                        n.half = 1'b1;
                        if (late) begin
                            // outputs change on the leading edge.
                            if (s.bit_idx > first_tx) begin
                                n.tx_sh = s.tx_sh << 1;
                            end
                            if (pulsed && cfg_i.master) begin
                                n.pins.frame_select_pin = (s.bit_idx == 5'h00);
                            end
                        end else if (s.bit_idx >= first_rx) begin
                            n.rx_sh = {s.rx_sh[DATA_W-2:0], rxd};
                        end
                    end else begin
                        n.half = 1'b0;
                        n.bit_idx = s.bit_idx + 5'h01;
                        if (!late) begin
                            n.tx_sh = s.tx_sh << 1;
                        end else if (s.bit_idx >= first_rx) begin
                            n.rx_sh = {s.rx_sh[DATA_W-2:0], rxd};
                        end
                        if (s.bit_idx == total - 5'h01) begin
                            n.st = cfg_i.master ? ST_TRAIL : ST_IDLE;
                            rx_push = !(pulsed && cfg_i.master);
                        end
                    end
                end
            end
            ST_TRAIL: begin
                if (tick) begin
                    if (pulsed) begin
                        n.pins.serial_clock_pin = !s.pins.serial_clock_pin;
                    end
                    // store on the rise after the LSB.
                    if (pulsed && !s.trail) begin
                        rx_push = 1'b1;
                    end
                    if (s.trail || !late) begin
                        // select stays low for the next word.
                        if (!pulsed && !halfdup && cfg_i.clock_phase_bit
                            && tx_level != '0) begin
                            n.tx_sh = load_word(tx_head, cfg_i);
                            tx_pop = 1'b1;
                            n.bit_idx = 5'h00;
                            n.half = 1'b0;
                            n.trail = 1'b0;
                            n.st = ST_LEAD;
                        end else begin
                            // select returns to its idle level after the word, high except in pulsed format.
                            n.pins = idle_pins(cfg_i);
                            n.st = ST_IDLE;
                        end
                    end else begin
                        n.trail = 1'b1;
                    end
                end
            end
            default: begin
                n.st = ST_IDLE;
            end
        endcase
        if (!cfg_i.enable) begin
            n.pins = idle_pins(cfg_i);
            n.st = ST_IDLE;
            tx_pop = 1'b0;
            rx_push = 1'b0;
        end
        if (n.st != ST_IDLE) begin
            n.pins.transmit_data_pin = n.tx_sh[DATA_W-1];
        end
        rx_word = n.rx_sh & (16'hffff >> (4'hf - cfg_i.size_m1));
        // restart on activity, read or empty store.
        if (s.st != ST_IDLE || rx_rd_i || rx_level == '0) begin
            n.to_cnt = 6'h00;
        end else if (half_tick && s.period && s.to_cnt != RX_TIMEOUT_BITS) begin
            n.to_cnt = s.to_cnt + 6'h01;
        end
        n.raw[INT_TX] = (tx_level <= SERVICE_LEVEL);
        n.raw[INT_RX] = (rx_level >= SERVICE_LEVEL);
        if (clear_timeout_i) begin
            n.raw[INT_TO] = 1'b0;
        end
        // timeout sets and wins over a clear.
        if (s.to_cnt != RX_TIMEOUT_BITS && n.to_cnt == RX_TIMEOUT_BITS) begin
            n.raw[INT_TO] = 1'b1;
        end
        if (clear_overrun_i) begin
            n.raw[INT_OV] = 1'b0;
        end
        // overrun on a push into a full store.
        if (rx_push && rx_level == FIFO_FULL) begin
            n.raw[INT_OV] = 1'b1;
        end
        n.masked = n.raw & cfg_i.mask;
        n.irq = |n.masked;
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            s <= CORE_RESET;
        end else begin
            s <= n;
        end
    end

    assign pins_o = s.pins;
    assign tx_level_o = tx_level;
    assign rx_level_o = rx_level;
    assign raw_status_o = s.raw;
    assign masked_status_o = s.masked;
    assign irq_o = s.irq;
endmodule : serial_port
`default_nettype wire

// ---- hw/word_fifo.sv ----
// Eight-word by sixteen-bit first-in first-out store with a registered head.
// Assumes writes to a full store and reads of an empty one are dropped.
`timescale 1ns/10ps
`default_nettype none
module word_fifo import ssp_pkg::*; (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic wr_i,
    input wire logic [DATA_W-1:0] wr_data_i,
    input wire logic rd_i,
    output logic [DATA_W-1:0] head_o,
    output logic [LVL_W-1:0] count_o
);
    fifo_state_t s;
    fifo_state_t n;
    logic wr_ok;
    logic rd_ok;

    always_comb begin
        n = s;
        wr_ok = wr_i && (s.count != FIFO_FULL);
        rd_ok = rd_i && (s.count != '0);
        if (wr_ok) begin
            n.mem[s.wr_ptr] = wr_data_i;
            n.wr_ptr = s.wr_ptr + 3'h1;
        end
        if (rd_ok) begin
            n.rd_ptr = s.rd_ptr + 3'h1;
        end
        n.count = s.count + {3'h0, wr_ok} - {3'h0, rd_ok};
        n.head = n.mem[n.rd_ptr];
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            s <= FIFO_RESET;
        end else begin
            s <= n;
        end
    end

    assign head_o = s.head;
    assign count_o = s.count;
endmodule : word_fifo
`default_nettype wire

// ---- shared/ssp_pkg.sv ----
// Constants and types shared by the synchronous serial port design.
// Assumes a single system clock domain; pins are synchronised in the core.
package ssp_pkg;
    localparam int DATA_W = 16;
    localparam int FIFO_DEPTH = 8;
    localparam int PTR_W = 3;
    localparam int LVL_W = 4;
    localparam logic [LVL_W-1:0] FIFO_FULL = 4'h8;
    localparam logic [LVL_W-1:0] SERVICE_LEVEL = 4'h4;
    localparam logic [1:0] FMT_SPI = 2'h0;
    localparam logic [1:0] FMT_PULSED = 2'h1;
    localparam logic [1:0] FMT_HALF = 2'h2;
    localparam logic [4:0] CTRL_MSG_BITS = 5'h08;
    localparam logic [4:0] TURN_BITS = 5'h01;
    localparam logic [4:0] PULSED_RX_FIRST = 5'h01;
    localparam logic [5:0] RX_TIMEOUT_BITS = 6'h20;
    localparam int INT_TX = 0;
    localparam int INT_RX = 1;
    localparam int INT_TO = 2;
    localparam int INT_OV = 3;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_LEAD = 4'h2,
        ST_BITS = 4'h4,
        ST_TRAIL = 4'h8
    } state_t;

    typedef struct packed {
        logic enable;
        logic master;
        logic loopback;
        logic [1:0] format;
        logic clock_polarity_bit;
        logic clock_phase_bit;
        logic [3:0] size_m1;
        logic [7:0] clock_prescale_divisor;
        logic [7:0] serial_clock_rate;
        logic [3:0] mask;
    } cfg_t;

    typedef struct packed {
        logic serial_clock_pin;
        logic serial_clock_pin_oe_n;
        logic frame_select_pin;
        logic frame_select_pin_oe_n;
        logic transmit_data_pin;
        logic transmit_data_pin_oe_n;
    } pins_t;

    typedef struct packed {
        logic [FIFO_DEPTH-1:0][DATA_W-1:0] mem;
        logic [PTR_W-1:0] wr_ptr;
        logic [PTR_W-1:0] rd_ptr;
        logic [LVL_W-1:0] count;
        logic [DATA_W-1:0] head;
    } fifo_state_t;

    typedef struct packed {
        logic [6:0] pre;
        logic [7:0] cnt;
        logic tick;
    } div_state_t;

    typedef struct packed {
        state_t st;
        logic [4:0] bit_idx;
        logic half;
        logic trail;
        logic [DATA_W-1:0] tx_sh;
        logic [DATA_W-1:0] rx_sh;
        logic [2:0] sync1;
        logic [2:0] sync2;
        logic sclk_prev;
        logic fss_prev;
        logic period;
        logic [5:0] to_cnt;
        pins_t pins;
        logic [3:0] raw;
        logic [3:0] masked;
        logic irq;
    } core_t;

    localparam pins_t PINS_RESET = 6'h1d;
    localparam fifo_state_t FIFO_RESET = '0;
    localparam div_state_t DIV_RESET = '0;
    localparam core_t CORE_RESET = '{st: ST_IDLE, pins: PINS_RESET,
        sync2: 3'h2, sync1: 3'h2, fss_prev: 1'b1, default: '0};
endpackage : ssp_pkg

// ---- tb/serial_port_assertions.sv ----
// Concurrent checks on the serial port top: store levels, status, pins.
// Assumes it is bound to the serial_port top and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module serial_port_checker import ssp_pkg::*; (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire cfg_t cfg_i,
    input wire logic tx_wr_i,
    input wire logic rx_rd_i,
    input wire logic clear_timeout_i,
    input wire logic clear_overrun_i,
    input wire pins_t pins_o,
    input wire logic [LVL_W-1:0] tx_level_o,
    input wire logic [LVL_W-1:0] rx_level_o,
    input wire logic [3:0] raw_status_o,
    input wire logic [3:0] masked_status_o,
    input wire logic irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    tx_push_a: assert property (
        tx_wr_i && !cfg_i.enable && tx_level_o != FIFO_FULL
        |=> tx_level_o == $past(tx_level_o) + 4'h1)
        else $error("push did not raise tx level");
    tx_refuse_a: assert property (
        tx_wr_i && !cfg_i.enable && tx_level_o == FIFO_FULL
        |=> tx_level_o == FIFO_FULL)
        else $error("full tx store changed level");
    rx_pop_a: assert property (
        rx_rd_i && !cfg_i.enable && rx_level_o != 4'h0
        |=> rx_level_o == $past(rx_level_o) - 4'h1)
        else $error("pop did not lower rx level");
    mask_view_a: assert property (
        $stable(cfg_i.mask) && $stable(raw_status_o)
        |-> masked_status_o == (raw_status_o & cfg_i.mask))
        else $error("masked status differs from raw and mask");
    irq_or_a: assert property (
        $stable(cfg_i.mask)
        |-> irq_o == (|(raw_status_o & cfg_i.mask)))
        else $error("interrupt line differs from masked status");
    overrun_hold_a: assert property (
        raw_status_o[INT_OV] && !clear_overrun_i |=> raw_status_o[INT_OV])
        else $error("overrun status dropped without clear");
    timeout_hold_a: assert property (
        raw_status_o[INT_TO] && !clear_timeout_i |=> raw_status_o[INT_TO])
        else $error("timeout status dropped without clear");
    pulsed_idle_a: assert property (
        !cfg_i.enable && !$past(cfg_i.enable) && !$past(sys_rst_i)
        && cfg_i.format == FMT_PULSED && $past(cfg_i.format) == FMT_PULSED
        |-> pins_o.transmit_data_pin_oe_n && !pins_o.serial_clock_pin
        && !pins_o.frame_select_pin)
        else $error("pulsed idle pins wrong");
    spi_quiet_a: assert property (
        cfg_i.master && cfg_i.format == FMT_SPI && $stable(cfg_i)
        && pins_o.frame_select_pin && $past(pins_o.frame_select_pin)
        && !$past(sys_rst_i, 2)
        |-> pins_o.serial_clock_pin == cfg_i.clock_polarity_bit)
        else $error("clock moved while select idle");
endmodule : serial_port_checker
bind serial_port serial_port_checker u_serial_port_checker (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .cfg_i(cfg_i),
    .tx_wr_i(tx_wr_i), .rx_rd_i(rx_rd_i),
    .clear_timeout_i(clear_timeout_i), .clear_overrun_i(clear_overrun_i),
    .pins_o(pins_o), .tx_level_o(tx_level_o), .rx_level_o(rx_level_o),
    .raw_status_o(raw_status_o), .masked_status_o(masked_status_o),
    .irq_o(irq_o));
`default_nettype wire

// ---- tb/spi_slave_model.sv ----
// Behavioural serial peripheral acting as slave on the port's far side.
// Assumes the port is master; the reply goes out MSB first in size bits.
`timescale 1ns/10ps
`default_nettype none
module spi_slave_model (
    input wire logic sclk_i,
    input wire logic fss_n_i,
    input wire logic mosi_i,
    input wire logic pol_i,
    input wire logic ph_i,
    input wire logic hd_i,
    input wire logic [4:0] size_i,
    input wire logic [15:0] reply_i,
    output logic miso_o,
    output logic [15:0] got_o
);
    logic [15:0] sh;
    int cnt;
    int drv;
    initial begin
        miso_o = 1'b0;
        got_o = '0;
        sh = '0;
        cnt = 0;
        drv = 0;
    end
    always @(negedge fss_n_i) begin
        got_o = '0;
        cnt = 0;
        drv = 0;
        sh = reply_i << (5'd16 - size_i);
        if (!ph_i && !hd_i) begin
            miso_o = sh[15];
            sh = sh << 1;
        end
    end
    // Released line shows the inverse of its last bit.
    always @(posedge fss_n_i) miso_o = ~miso_o;
    always @(sclk_i) begin
        if (!fss_n_i) begin
            if ((sclk_i != pol_i) != ph_i) begin
                if (!hd_i || cnt < 8) begin
                    got_o = {got_o[14:0], mosi_i};
                end
                cnt = cnt + 1;
            end else if (hd_i && drv < 8) begin
                // reply waits one clock after the message.
                drv = drv + 1;
            end else begin
                if (ph_i && cnt == int'(size_i)) begin
                    cnt = 0;
                    got_o = '0;
                    sh = reply_i << (5'd16 - size_i);
                end
                miso_o = sh[15];
                sh = sh << 1;
            end
        end
    end
endmodule : spi_slave_model
`default_nettype wire

// ---- tb/tb_serial_port.sv ----
// Self-checking bench for the serial port core with a slave model.
// Assumes the master reads back its own clock and select pins.
`timescale 1ns/10ps
`default_nettype none
module tb_serial_port import ssp_pkg::*; ;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    cfg_t cfg = '0;
    logic tx_wr = 1'b0, rx_rd = 1'b0, clr_to = 1'b0, clr_ov = 1'b0;
    logic [15:0] tx_data = '0, rx_data, got, reply = '0, keep;
    pins_t pins;
    logic [3:0] tx_lvl, rx_lvl, raw, msk;
    logic irq, miso, sclk_q = 1'b0, fss_q = 1'b1;
    int fails = 0, total_checks = 0, cyc = 0, rises = 0, fss_rises = 0;
    int last_rise = 0, per = 0, hi_run = 0, hi_len = 0, size = 8, r0;
    always #25 clk_i = ~clk_i;
    serial_port u_serial_port (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .cfg_i(cfg), .tx_wr_i(tx_wr), .tx_data_i(tx_data), .rx_rd_i(rx_rd),
        .clear_timeout_i(clr_to), .clear_overrun_i(clr_ov),
        .serial_clock_pin_i(pins.serial_clock_pin),
        .frame_select_pin_i(pins.frame_select_pin),
        .receive_data_pin_i(miso), .pins_o(pins), .rx_data_o(rx_data),
        .tx_level_o(tx_lvl), .rx_level_o(rx_lvl), .raw_status_o(raw),
        .masked_status_o(msk), .irq_o(irq));
    spi_slave_model u_spi_slave_model (.sclk_i(pins.serial_clock_pin),
        .fss_n_i(pins.frame_select_pin), .mosi_i(pins.transmit_data_pin),
        .pol_i(cfg.clock_polarity_bit), .ph_i(cfg.clock_phase_bit),
        .size_i(5'(size)), .reply_i(reply), .hd_i(cfg.format == FMT_HALF),
        .miso_o(miso), .got_o(got));
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        sclk_q <= pins.serial_clock_pin;
        fss_q <= pins.frame_select_pin;
        if (pins.serial_clock_pin && !sclk_q && !pins.frame_select_pin) begin
            rises <= rises + 1;
            per <= cyc - last_rise;
            last_rise <= cyc;
        end
        if (pins.frame_select_pin && !fss_q) fss_rises <= fss_rises + 1;
        hi_run <= pins.frame_select_pin ? hi_run + 1 : 0;
        if (!pins.frame_select_pin && fss_q) hi_len <= hi_run;
    end
    task automatic check(input logic [15:0] a, input logic [15:0] e,
                         input string m);
        total_checks++;
        if (a !== e) begin
            fails++;
            $display("BAD %0t %s got %h want %h", $time, m, a, e);
        end
    endtask : check
    task automatic setup(input logic [1:0] f, input logic [1:0] m,
                         input logic lb, input logic [7:0] pr,
                         input logic [7:0] rt);
        @(posedge clk_i);
        cfg <= '{enable: 1'b0, master: 1'b1, loopback: lb, format: f,
                 clock_polarity_bit: m[1], clock_phase_bit: m[0],
                 size_m1: 4'(size - 1), clock_prescale_divisor: pr,
                 serial_clock_rate: rt, mask: 4'h0};
    endtask : setup
    task automatic go();
        @(posedge clk_i);
        cfg.enable <= 1'b1;
    endtask : go
    task automatic push(input logic [15:0] w);
        @(posedge clk_i);
        tx_wr <= 1'b1;
        tx_data <= w;
        @(posedge clk_i);
        tx_wr <= 1'b0;
    endtask : push
    task automatic pop(input logic [15:0] e);
        repeat (2) @(posedge clk_i);
        check(rx_data, e, "rx word");
        rx_rd <= 1'b1;
        @(posedge clk_i);
        rx_rd <= 1'b0;
    endtask : pop
    task automatic wait_rx(input int n);
        for (int i = 0; i < 3000 && rx_lvl != n; i++) @(posedge clk_i);
        repeat (30) @(posedge clk_i);
    endtask : wait_rx
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : finish_test
    initial begin
        repeat (20000) @(posedge clk_i);
        fails++;
        finish_test();
    end
    initial begin
        repeat (3) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_i);
        check({raw, msk, tx_lvl, rx_lvl}, 16'h0000, "reset state");
        check(16'(pins), 16'h001d, "reset pins");
        setup(FMT_SPI, 2'h0, 1'b1, 8'h02, 8'h00);
        for (int i = 0; i < 9; i++) push(16'ha500 + 16'(i));
        repeat (2) @(posedge clk_i);
        check(tx_lvl, 16'h0008, "tx full");
        check(raw[INT_TX], 16'h0000, "tx service");
        go();
        wait_rx(8);
        check(rx_lvl, 16'h0008, "rx level");
        check(raw[1:0], 16'h0003, "service bits");
        push(16'h5a77);
        repeat (160) @(posedge clk_i);
        check(raw[3:2], 16'h0003, "overrun and timeout");
        cfg.mask <= 4'h8;
        repeat (3) @(posedge clk_i);
        check({msk, 3'h0, irq}, 16'h0081, "masked overrun");
        clr_ov <= 1'b1;
        @(posedge clk_i);
        clr_ov <= 1'b0;
        repeat (3) @(posedge clk_i);
        check({raw[INT_TO], irq}, 16'h0002, "mask hides timeout");
        cfg.enable <= 1'b0;
        for (int i = 0; i < 8; i++) pop(16'(i));
        $display("fifo and status test done");
        for (int m = 0; m < 4; m++) begin
            size = 4 + 4 * m;
            keep = 16'((32'h1 << size) - 1);
            reply = 16'h9c3b ^ 16'(m);
            setup(FMT_SPI, 2'(m), 1'b0, 8'h04, 8'h02);
            r0 = fss_rises;
            push(16'h2d5e + 16'(m));
            push(16'he1a7 - 16'(m));
            go();
            wait_rx(2);
            check(got, (16'he1a7 - 16'(m)) & keep, "slave saw");
            check(fss_rises - r0, m[0] ? 1 : 2, "select rises");
            check(per, 16'd12, "bit period");
            check(pins.serial_clock_pin, m[1], "idle clock");
            pop(reply & keep);
            pop(reply & keep);
        end
        $display("spi mode test done");
        size = 8;
        setup(FMT_PULSED, 2'h0, 1'b1, 8'h04, 8'h02);
        push(16'h73b6);
        go();
        wait_rx(1);
        check(hi_len, 16'd12, "sync width");
        check({pins.serial_clock_pin, pins.frame_select_pin,
               pins.transmit_data_pin_oe_n}, 16'h0001, "pulsed idle");
        check({pins.serial_clock_pin_oe_n, pins.frame_select_pin_oe_n},
              16'h0000, "master drives");
        pop(16'h00b6);
        $display("pulsed test done");
        setup(FMT_HALF, 2'h0, 1'b0, 8'h04, 8'h02);
        r0 = rises;
        push(16'h0042);
        go();
        wait_rx(1);
        check(rises - r0, 16'd17, "frame clocks");
        check(got, 16'h0042, "control message");
        pop(reply & 16'h00ff);
        $display("half duplex test done");
        finish_test();
    end
endmodule : tb_serial_port
`default_nettype wire
